// File: rtl/light_readout.sv
`timescale 1ns/1ps
// Contract
// - Range/resolution register low nibble, upper zero.
// - Range code selects one of four scales; the logic only stores it, no port carries it.
// - Resolution code sets cycles and result width.
// - Resolution change also changes integration period.
// - Integration lasts two-to-n oscillator periods.
// - Only sixteen-bit setting rejects mains flicker.
// - Result bytes at 0x02/0x03, read-only.
// - Result right-aligned from bit zero.
// - Result updated per conversion, zero after reset.
// - Result at or below lower threshold interrupts.
// - Result at or above upper threshold interrupts.
// - Thresholds are byte pairs, low byte even.
// - Lower threshold resets 0x00, upper 0xff.
// - Test register reads zero, host writes zero.
// - Persistence needs 1, 4, 8, 16 hits.
// - Active-low interrupt and flag clear on read.
// - Three-bit mode selects off, once, continuous.
module light_readout
    import light_pkg::*;
#(
    parameter int CYC16 = CYC_RES16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port from the serial engine
    input wire reg_req_t req,
    output logic [7:0] rdata_r,
    // Analog front end
    input wire logic [15:0] sample,
    output logic meas_ir_r,
    output logic integrating_r,
    // Interrupt pin
    output logic int_n_r
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } conv_state_t;

    conv_state_t state_r;
    logic [2:0] mode_r;
    logic [1:0] persist_r;
    logic [7:0] range_res_r;
    logic [15:0] result_r;
    logic [15:0] lower_r;
    logic [15:0] upper_r;
    logic flag_r;
    logic flag_nxt;
    logic single_pend_r;
    logic [4:0] hit_cnt_r;
    logic start;
    logic abort;
    logic done;
    logic outside;
    logic hit_now;
    logic als_done;
    logic [15:0] captured;
    logic [15:0] result_vis;
    logic [1:0] res_sel;

    // Mode decoding shared by the sequencer and the window check.
    function automatic logic mode_runs(input logic [2:0] m);
        mode_runs = (m == MODE_ALS_ONCE) || (m == MODE_IR_ONCE) ||
                    (m == MODE_ALS_CONT) || (m == MODE_IR_CONT);
    endfunction

    function automatic logic mode_is_ir(input logic [2:0] m);
        mode_is_ir = (m == MODE_IR_ONCE) || (m == MODE_IR_CONT);
    endfunction

    function automatic logic mode_is_cont(input logic [2:0] m);
        mode_is_cont = (m == MODE_ALS_CONT) || (m == MODE_IR_CONT);
    endfunction

    // Keeps only the bits that the given resolution produces.
    function automatic logic [15:0] width_mask(input logic [1:0] r);
        case (r)
            2'b00: width_mask = 16'hffff;
            2'b01: width_mask = 16'h0fff;
            2'b10: width_mask = 16'h00ff;
            default: width_mask = 16'h000f;
        endcase
    endfunction

    function automatic logic [4:0] persist_need(input logic [1:0] p);
        case (p)
            2'b00: persist_need = 5'h01;
            2'b01: persist_need = 5'h04;
            2'b10: persist_need = 5'h08;
            default: persist_need = 5'h10;
        endcase
    endfunction

    function automatic logic is_wr(input reg_req_t q, input logic [7:0] a);
        is_wr = q.wr && (q.addr == a);
    endfunction

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    assign res_sel = range_res_r[POS_RES +: 2];

    // Mode and persistence; the flag bit is status and not writable.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_r <= RST_MODE_PERSIST[POS_MODE +: 3];
            persist_r <= RST_MODE_PERSIST[POS_PERSIST +: 2];
        end else if (is_wr(req, OFS_MODE_PERSIST)) begin
            mode_r <= req.wdata[POS_MODE +: 3];
            persist_r <= req.wdata[POS_PERSIST +: 2];
        end
    end

    // Range code drives no output; the logic only stores it for read-back.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            range_res_r <= RST_RANGE_RES;
        end else if (is_wr(req, OFS_RANGE_RES)) begin
            range_res_r <= {4'h0, req.wdata[3:0]};
        end
    end

    // Threshold byte pairs, even offset being the low byte.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lower_r <= {RST_LOWER, RST_LOWER};
            upper_r <= {RST_UPPER, RST_UPPER};
        end else begin
            if (is_wr(req, OFS_LOWER_LO)) lower_r[7:0] <= req.wdata;
            if (is_wr(req, OFS_LOWER_HI)) lower_r[15:8] <= req.wdata;
            if (is_wr(req, OFS_UPPER_LO)) upper_r[7:0] <= req.wdata;
            if (is_wr(req, OFS_UPPER_HI)) upper_r[15:8] <= req.wdata;
        end
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // A new resolution or mode aborts the conversion, so a result is
    // never built from a mix of two integration lengths.
    assign abort = (state_r == ST_RUN) && (is_wr(req, OFS_RANGE_RES) ||
                   (is_wr(req, OFS_MODE_PERSIST) && req.wdata[POS_MODE +: 3] != mode_r));
    assign start = (state_r == ST_IDLE) && !req.wr && mode_runs(mode_r) &&
                   (mode_is_cont(mode_r) || single_pend_r);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (abort || done) state_r <= ST_IDLE;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // A single-shot mode converts once per write, then powers down.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            single_pend_r <= 1'b0;
        end else if (is_wr(req, OFS_MODE_PERSIST)) begin
            single_pend_r <= mode_runs(req.wdata[POS_MODE +: 3]) &&
                             !mode_is_cont(req.wdata[POS_MODE +: 3]);
        end else if (start) begin
            single_pend_r <= 1'b0;
        end
    end

    // Front end controls: integrate window and channel select.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            integrating_r <= 1'b0;
            meas_ir_r <= 1'b0;
        end else begin
            integrating_r <= (state_r == ST_RUN) ? !(abort || done) : start;
            meas_ir_r <= mode_is_ir(mode_r);
        end
    end

    // Only the sixteen-bit period spans whole mains cycles, so shorter
    // settings trade flicker rejection for speed.
    integ_timer #(
        .CYC16(CYC16),
        .DIV(OSC_DIV)
    ) integ_timer_i (
        .clk(ref_clk),
        .rst(rst),
        .start(start),
        .abort(abort),
        .res_sel(res_sel),
        .done(done)
    );

    // ----------------------------------------------------------------
    // Result and window comparison
    // ----------------------------------------------------------------
    assign captured = sample & width_mask(res_sel);
    assign als_done = done && (state_r == ST_RUN) && !mode_is_ir(mode_r);
    assign outside = (captured <= lower_r) || (captured >= upper_r);
    assign hit_now = als_done && outside && ((hit_cnt_r + 5'h01) >= persist_need(persist_r));

    // Result has no write path at all; host writes there are dropped.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            result_r <= {RST_RESULT, RST_RESULT};
        end else if (done && state_r == ST_RUN) begin
            result_r <= captured;
        end
    end

    // Consecutive out-of-window count, saturating at the largest need.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            hit_cnt_r <= 5'h00;
        end else if (als_done) begin
            if (!outside) begin
                hit_cnt_r <= 5'h00;
            end else if (hit_cnt_r != 5'h10) begin
                hit_cnt_r <= hit_cnt_r + 5'h01;
            end
        end
    end

    // Flag is sticky until mode register is read; a new hit wins.
    always_comb begin
        flag_nxt = flag_r;
        if (req.rd && req.addr == OFS_MODE_PERSIST) flag_nxt = 1'b0;
        if (hit_now) flag_nxt = 1'b1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_r <= 1'b0;
            int_n_r <= 1'b1;
        end else begin
            flag_r <= flag_nxt;
            int_n_r <= !flag_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    // Result is masked again on read so a narrower resolution chosen
    // after a conversion never exposes old high-order bits.
    assign result_vis = result_r & width_mask(res_sel);

    // Read data is registered at the edge that takes the strobe.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                OFS_MODE_PERSIST: rdata_r <= {mode_r, 2'b00, flag_r, persist_r};
                OFS_RANGE_RES: rdata_r <= range_res_r;
                OFS_RESULT_LO: rdata_r <= result_vis[7:0];
                OFS_RESULT_HI: rdata_r <= result_vis[15:8];
                OFS_LOWER_LO: rdata_r <= lower_r[7:0];
                OFS_LOWER_HI: rdata_r <= lower_r[15:8];
                OFS_UPPER_LO: rdata_r <= upper_r[7:0];
                OFS_UPPER_HI: rdata_r <= upper_r[15:8];
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_trip;
        als_done && outside && persist_r == 2'b00;
    endsequence

    sequence s_flag_up;
        ##1 (flag_r && !int_n_r);
    endsequence

    a_upper_zero: assert property (range_res_r[7:4] == 4'h0)
        else $error("Range register upper nibble not zero.");
    a_trip_now: assert property (s_trip |-> s_flag_up)
        else $error("Out-of-window result did not raise the interrupt.");
    a_trip_high: assert property (als_done && captured >= upper_r && persist_r == 2'b00
                                  |=> flag_r)
        else $error("Upper threshold crossing missed.");
    a_persist_need: assert property ($rose(flag_r) |->
                                     $past(hit_cnt_r) + 5'h01 >= persist_need($past(persist_r)))
        else $error("Interrupt raised before persistence count met.");
    a_flag_clear: assert property (req.rd && req.addr == OFS_MODE_PERSIST && !hit_now
                                   |=> !flag_r && int_n_r)
        else $error("Flag not cleared by mode register read.");
    a_result_ro: assert property (req.wr && !done |=> result_r == $past(result_r))
        else $error("Result changed without a conversion.");
    a_test_zero: assert property (req.rd && req.addr == OFS_TEST |=> rdata_r == 8'h00)
        else $error("Test register read not zero.");
    a_width_mask: assert property (req.rd && req.addr == OFS_RESULT_HI && res_sel[1]
                                   |=> rdata_r == 8'h00)
        else $error("High result byte not zero at narrow resolution.");
    a_off_idle: assert property (mode_r == MODE_OFF |=> state_r == ST_IDLE && !integrating_r)
        else $error("Conversion running in power-down.");

endmodule

// File: rtl/light_pkg.sv
package light_pkg;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_MODE_PERSIST = 8'h00;
    localparam logic [7:0] OFS_RANGE_RES = 8'h01;
    localparam logic [7:0] OFS_RESULT_LO = 8'h02;
    localparam logic [7:0] OFS_RESULT_HI = 8'h03;
    localparam logic [7:0] OFS_LOWER_LO = 8'h04;
    localparam logic [7:0] OFS_LOWER_HI = 8'h05;
    localparam logic [7:0] OFS_UPPER_LO = 8'h06;
    localparam logic [7:0] OFS_UPPER_HI = 8'h07;
    localparam logic [7:0] OFS_TEST = 8'h08;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_MODE_PERSIST = 8'h00;
    localparam logic [7:0] RST_RANGE_RES = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_LOWER = 8'h00;
    localparam logic [7:0] RST_UPPER = 8'hff;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int POS_PERSIST = 0;
    localparam int POS_FLAG = 2;
    localparam int POS_MODE = 5;
    localparam int POS_FULLSCALE = 0;
    localparam int POS_RES = 2;

    // Operating mode codes.
    localparam logic [2:0] MODE_OFF = 3'h0;
    localparam logic [2:0] MODE_ALS_ONCE = 3'h1;
    localparam logic [2:0] MODE_IR_ONCE = 3'h2;
    localparam logic [2:0] MODE_ALS_CONT = 3'h5;
    localparam logic [2:0] MODE_IR_CONT = 3'h6;

    // ----------------------------------------------------------------
    // Timing: oscillator cycles per conversion and oscillator rate
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int OSC_HZ = 725_000;
    localparam int OSC_DIV = CLK_HZ / OSC_HZ;
    localparam int CYC_RES16 = 65_536;
    localparam int CYC_RES12 = 4_096;
    localparam int CYC_RES8 = 256;
    localparam int CYC_RES4 = 16;

    // Register port request as issued by the serial engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

endpackage

// File: rtl/integ_timer.sv
`timescale 1ns/1ps
module integ_timer
    import light_pkg::*;
#(
    parameter int CYC16 = CYC_RES16,
    parameter int DIV = OSC_DIV
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic abort,
    input wire logic [1:0] res_sel,
    // Status
    output logic done
);

    logic [7:0] div_cnt_r;
    logic tick;
    logic [16:0] cyc_cnt_r;
    logic active_r;

    // Last oscillator cycle index, cycles per conversion minus one, for each resolution code.
    function automatic logic [16:0] cycles_last(input logic [1:0] r);
        case (r)
            2'b00: cycles_last = 17'(CYC16 - 1);
            2'b01: cycles_last = 17'(CYC_RES12 - 1);
            2'b10: cycles_last = 17'(CYC_RES8 - 1);
            default: cycles_last = 17'(CYC_RES4 - 1);
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Oscillator enable divider
    // ----------------------------------------------------------------
    // Free running, so a conversion starts at any phase of the oscillator period.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_r <= 8'h00;
        end else if (div_cnt_r == 8'(DIV - 1)) begin
            div_cnt_r <= 8'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    assign tick = (div_cnt_r == 8'(DIV - 1));

    // Integration counts two to the n oscillator ticks; the first period after start may be partial.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            cyc_cnt_r <= 17'h00000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                active_r <= 1'b0;
            end else if (start) begin
                active_r <= 1'b1;
                cyc_cnt_r <= 17'h00000;
            end else if (active_r && tick) begin
                if (cyc_cnt_r == cycles_last(res_sel)) begin
                    active_r <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cyc_cnt_r <= cyc_cnt_r + 17'h00001;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_integ_length: assert property (done |-> $past(cyc_cnt_r) == cycles_last(res_sel))
        else $error("Conversion ended after the wrong number of oscillator cycles.");

endmodule

// File: testbench/light_host.sv
`timescale 1ns/1ps
module light_host
    import light_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Register port toward the device
    output reg_req_t req,
    input wire logic [7:0] rdata_r
);
    // The port idles with both strobes low from time zero.
    initial begin
        req = '0;
    end

    // One byte write; the strobe spans exactly one rising edge.
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(negedge ref_clk);
        req.wr = 1'b1;
        req.addr = addr;
        req.wdata = (addr == OFS_TEST) ? 8'h00 : data;
        @(negedge ref_clk);
        req = '0;
    endtask

    // One byte read; the answer is registered at the edge that takes the strobe.
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge ref_clk);
        req.rd = 1'b1;
        req.addr = addr;
        @(negedge ref_clk);
        data = rdata_r;
        req = '0;
    endtask
endmodule

// File: testbench/light_readout_test.sv
`timescale 1ns/1ps
module light_readout_test;
    import light_pkg::*;
    // A short 16-bit conversion keeps the run well inside the cycle budget.
    localparam int C16 = 64;
    localparam int TICK = 34;
    logic ref_clk;
    logic rst = 1'b1;
    reg_req_t req;
    logic [7:0] rdata_r;
    logic [15:0] sample = 16'h0000;
    logic meas_ir_r;
    logic integrating_r;
    logic int_n_r;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    light_readout #(.CYC16(C16)) light_readout_i (.ref_clk(ref_clk), .rst(rst), .req(req),
        .rdata_r(rdata_r), .sample(sample), .meas_ir_r(meas_ir_r),
        .integrating_r(integrating_r), .int_n_r(int_n_r));
    light_host light_host_i (.ref_clk(ref_clk), .req(req), .rdata_r(rdata_r));

    // 25 MHz reference clock.
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic close_out;
        $display("Comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hung handshake must not stall the run forever.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        light_host_i.write_reg(a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string what);
        logic [7:0] d;
        light_host_i.read_reg(a, d);
        chk(what, {8'h00, e}, {8'h00, d});
    endtask

    task automatic do_reset;
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
    endtask

    // Waits for one whole conversion and returns its length in cycles.
    task automatic wait_conv(output int len);
        int guard;
        guard = 0;
        len = 0;
        while (integrating_r !== 1'b1 && guard < 200) begin
            @(negedge ref_clk);
            guard++;
        end
        while (integrating_r === 1'b1 && len < 20000) begin
            @(negedge ref_clk);
            len++;
        end
        chk("conversion handshake", 16'h0001, {15'h0, guard < 200 && len < 20000});
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] tab [0:9];
        int i;
        tab = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};
        chk("int pin idle", 16'h0001, {15'h0, int_n_r});
        chk("integrating idle", 16'h0000, {15'h0, integrating_r});
        for (i = 0; i < 10; i++) begin
            rchk(8'(i), tab[i], "reset value");
        end
        $display("t_reset done");
    endtask

    task automatic t_ctrl;
        int k;
        for (k = 0; k < 16; k++) begin
            wr(OFS_RANGE_RES, {4'ha, 4'(k)});
            rchk(OFS_RANGE_RES, {4'h0, 4'(k)}, "range resolution");
        end
        wr(OFS_RANGE_RES, 8'h00);
        wr(OFS_TEST, 8'h00);
        rchk(OFS_TEST, 8'h00, "test register");
        $display("t_ctrl done");
    endtask

    // Single ambient conversions at three widths, then masking at read time.
    task automatic t_conv;
        logic [1:0] code [0:2];
        int ticks [0:2];
        logic [15:0] mask [0:2];
        int i;
        int len;
        code = '{2'h3, 2'h2, 2'h0};
        ticks = '{16, 256, C16};
        mask = '{16'h000f, 16'h00ff, 16'hffff};
        sample = 16'hfedc;
        for (i = 0; i < 3; i++) begin
            wr(OFS_RANGE_RES, {4'h0, code[i], 2'h1});
            wr(OFS_MODE_PERSIST, {MODE_ALS_ONCE, 5'h00});
            wait_conv(len);
            compares++;
            if (len < (ticks[i] - 1) * TICK || len > (ticks[i] + 1) * TICK + 2) begin
                n_fail++;
                $display("Error conversion length expected %0d seen %0d", ticks[i] * TICK, len);
            end
            repeat (40) @(negedge ref_clk);
            chk("single stops", 16'h0000, {15'h0, integrating_r});
            rchk(OFS_RESULT_LO, mask[i][7:0] & 8'hdc, "result low");
            rchk(OFS_RESULT_HI, mask[i][15:8] & 8'hfe, "result high");
        end
        wr(OFS_RANGE_RES, 8'h04);
        rchk(OFS_RESULT_HI, 8'h0e, "twelve bit high");
        wr(OFS_RANGE_RES, 8'h00);
        wr(OFS_RESULT_LO, 8'h11);
        wr(OFS_RESULT_HI, 8'h22);
        rchk(OFS_RESULT_LO, 8'hdc, "result low kept");
        rchk(OFS_RESULT_HI, 8'hfe, "result high kept");
        chk("no window hit", 16'h0001, {15'h0, int_n_r});
        $display("t_conv done");
    endtask

    // Window edges, persistence, clear on read and infrared exclusion.
    task automatic t_window;
        int i;
        int len;
        do_reset();
        wr(OFS_RANGE_RES, 8'h0c);
        wr(OFS_LOWER_LO, 8'h05);
        wr(OFS_LOWER_HI, 8'h00);
        wr(OFS_UPPER_LO, 8'h0c);
        wr(OFS_UPPER_HI, 8'h00);
        rchk(OFS_LOWER_LO, 8'h05, "lower low byte");
        rchk(OFS_UPPER_HI, 8'h00, "upper high byte");
        sample = 16'hfff5;
        wr(OFS_MODE_PERSIST, {MODE_ALS_CONT, 5'h01});
        for (i = 0; i < 3; i++) begin
            wait_conv(len);
            chk("pin before count", 16'h0001, {15'h0, int_n_r});
        end
        wait_conv(len);
        chk("pin at lower edge", 16'h0000, {15'h0, int_n_r});
        rchk(OFS_MODE_PERSIST, 8'ha5, "flag read");
        chk("pin cleared", 16'h0001, {15'h0, int_n_r});
        sample = 16'h0006;
        wait_conv(len);
        chk("inside window", 16'h0001, {15'h0, int_n_r});
        sample = 16'h000c;
        wr(OFS_MODE_PERSIST, {MODE_ALS_CONT, 5'h00});
        wait_conv(len);
        chk("pin at upper edge", 16'h0000, {15'h0, int_n_r});
        rchk(OFS_MODE_PERSIST, 8'ha4, "flag read upper");
        wr(OFS_MODE_PERSIST, {MODE_IR_CONT, 5'h00});
        wait_conv(len);
        chk("infrared selected", 16'h0001, {15'h0, meas_ir_r});
        chk("infrared no window", 16'h0001, {15'h0, int_n_r});
        wr(OFS_RANGE_RES, 8'h0c);
        chk("resolution write aborts", 16'h0000, {15'h0, integrating_r});
        wr(OFS_MODE_PERSIST, 8'h00);
        // The channel select is registered from the mode, one cycle later.
        @(negedge ref_clk);
        chk("infrared off", 16'h0000, {15'h0, meas_ir_r});
        $display("t_window done");
    endtask

    // Main sequence.
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_ctrl();
        t_conv();
        t_window();
        close_out();
    end
endmodule
